// ===== rtl/rbi_pkg.sv
package rbi_pkg;

  // Internal clocks held in reset after the external reset is released
  localparam int unsigned RELEASE_CYCLES = 32;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] RELEASE_COUNT = CNT_W'(RELEASE_CYCLES);

  // Number of external request lines and their positions
  localparam int unsigned REQ_LINES = 2;
  localparam int unsigned REQ_A = 0;
  localparam int unsigned REQ_B = 1;

  typedef enum logic [1:0] {
    RBI_IN_RESET,
    RBI_COUNTING,
    RBI_RUNNING
  } rbi_state_type;

  // Interrupt request line configuration: edge mode and enable
  typedef struct packed {
    logic edge_mode;
    logic enable;
  } rbi_irq_cfg_type;

  // State of one request input conditioner
  typedef struct packed {
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic pending_r;
  } rbi_irq_state_type;

  // State of the reset sequencer
  typedef struct packed {
    logic rst_sync1_r;
    logic rst_sync2_r;
    rbi_state_type state_r;
    logic [CNT_W-1:0] count_r;
    logic core_reset_r;
    logic reset_ind_n_r;
    logic offchip_boot_r;
    logic debug_reset_r;
    logic irq_a_r;
    logic irq_b_r;
  } rbi_seq_type;

endpackage

// ===== rtl/rbi_irq_cond.sv
`timescale 1ns/1ns
`default_nettype none

// One external request line: two-stage sync, level or falling-edge detection
module rbi_irq_cond (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_n_in,
  input wire rbi_pkg::rbi_irq_cfg_type cfg_in,
  input wire logic ack_in,
  output logic req_out
);

  rbi_pkg::rbi_irq_state_type st_r;
  rbi_pkg::rbi_irq_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sync1_r = req_n_in;
    st_nxt.sync2_r = st_r.sync1_r;
    st_nxt.prev_r = st_r.sync2_r;
    // Latched falling edge; a new edge in the ack cycle wins over the clear
    if (st_r.prev_r && !st_r.sync2_r && cfg_in.enable && cfg_in.edge_mode)
      st_nxt.pending_r = 1'b1;
    else if (ack_in || !cfg_in.edge_mode || !cfg_in.enable)
      st_nxt.pending_r = 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      st_r <= '{sync1_r: 1'b1, sync2_r: 1'b1, prev_r: 1'b1, pending_r: 1'b0};
    else
      st_r <= st_nxt;
  end

  assign req_out = cfg_in.enable &&
                   (cfg_in.edge_mode ? st_r.pending_r : !st_r.sync2_r);

endmodule
`default_nettype wire

// ===== rtl/rbi_reset_boot_irq.sv
// Contract
// - Request A is synchronised; level or falling-edge mode is selectable.
// - Request B is accepted; level or falling-edge mode is selectable.
// - Reset indicator output always mirrors the internal reset.
// - While external reset is low, the core stays held in reset.
// - On external reset release the boot-select level is captured.
// - Internal reset releases synchronously after a fixed count of clocks.
// - Device reset alone leaves the debug and test-port logic unreset; the code raises debug_reset_r on the pin reset.
// - Boot select high means off-chip boot; captured level picks boot source.
`timescale 1ns/1ns
`default_nettype none

module rbi_reset_boot_irq #(
  parameter int unsigned RELEASE_CYCLES = rbi_pkg::RELEASE_CYCLES
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ext_reset_n_in,
  input wire logic offchip_boot_select_in,
  input wire logic ext_request_a_n_in,
  input wire logic ext_request_b_n_in,
  input wire rbi_pkg::rbi_irq_cfg_type cfg_a_in,
  input wire rbi_pkg::rbi_irq_cfg_type cfg_b_in,
  input wire logic ack_a_in,
  input wire logic ack_b_in,
  output logic core_reset_out,
  output logic reset_indicator_n_out,
  output logic offchip_boot_out,
  output logic core_only_reset_out,
  output logic irq_a_out,
  output logic irq_b_out
);

  localparam logic [rbi_pkg::CNT_W-1:0] REL_CNT = rbi_pkg::CNT_W'(RELEASE_CYCLES);

  rbi_pkg::rbi_seq_type seq_r;
  rbi_pkg::rbi_seq_type seq_nxt;
  // Request lines gathered so that one conditioner loop serves both
  logic [rbi_pkg::REQ_LINES-1:0] req_pin_n;
  rbi_pkg::rbi_irq_cfg_type [rbi_pkg::REQ_LINES-1:0] req_cfg;
  logic [rbi_pkg::REQ_LINES-1:0] req_ack;
  logic [rbi_pkg::REQ_LINES-1:0] req_seen;

  assign req_pin_n = {ext_request_b_n_in, ext_request_a_n_in};
  assign req_cfg = {cfg_b_in, cfg_a_in};
  assign req_ack = {ack_b_in, ack_a_in};

  for (genvar i = 0; i < rbi_pkg::REQ_LINES; i++)
  begin : g_req
    rbi_irq_cond u_cond (
      .clk_in(clk_in),
      .srst_in(srst_in),
      .req_n_in(req_pin_n[i]),
      .cfg_in(req_cfg[i]),
      .ack_in(req_ack[i]),
      .req_out(req_seen[i])
    );
  end

  always_comb
  begin
    seq_nxt = seq_r;
    // Reset pin synchroniser; only the second flop is read below
    seq_nxt.rst_sync1_r = ext_reset_n_in;
    seq_nxt.rst_sync2_r = seq_r.rst_sync1_r;
    // Requests are masked while the core sits in reset
    seq_nxt.irq_a_r = req_seen[rbi_pkg::REQ_A] && !seq_r.core_reset_r;
    seq_nxt.irq_b_r = req_seen[rbi_pkg::REQ_B] && !seq_r.core_reset_r;
    case (seq_r.state_r)
      rbi_pkg::RBI_IN_RESET:
      begin
        seq_nxt.core_reset_r = 1'b1;
        seq_nxt.debug_reset_r = 1'b1;
        if (seq_r.rst_sync2_r)
        begin
          seq_nxt.offchip_boot_r = offchip_boot_select_in;
          seq_nxt.count_r = (REL_CNT > rbi_pkg::CNT_ONE) ?
                            REL_CNT - rbi_pkg::CNT_ONE : rbi_pkg::CNT_ZERO;
          seq_nxt.state_r = rbi_pkg::RBI_COUNTING;
        end
      end
      rbi_pkg::RBI_COUNTING:
      begin
        seq_nxt.debug_reset_r = 1'b0;
        if (!seq_r.rst_sync2_r)
          seq_nxt.state_r = rbi_pkg::RBI_IN_RESET;
        else if (seq_r.count_r == rbi_pkg::CNT_ZERO)
        begin
          seq_nxt.core_reset_r = 1'b0;
          seq_nxt.state_r = rbi_pkg::RBI_RUNNING;
        end
        else
          seq_nxt.count_r = seq_r.count_r - rbi_pkg::CNT_ONE;
      end
      rbi_pkg::RBI_RUNNING:
      begin
        seq_nxt.debug_reset_r = 1'b0;
        if (!seq_r.rst_sync2_r)
        begin
          seq_nxt.core_reset_r = 1'b1;
          seq_nxt.state_r = rbi_pkg::RBI_IN_RESET;
        end
      end
      default:
      begin
        seq_nxt.core_reset_r = 1'b1;
        seq_nxt.state_r = rbi_pkg::RBI_IN_RESET;
      end
    endcase
    seq_nxt.reset_ind_n_r = !seq_nxt.core_reset_r;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      // Pin is taken as low until two clean samples say otherwise
      seq_r.rst_sync1_r <= 1'b0;
      seq_r.rst_sync2_r <= 1'b0;
      seq_r.state_r <= rbi_pkg::RBI_IN_RESET;
      seq_r.count_r <= rbi_pkg::CNT_ZERO;
      seq_r.core_reset_r <= 1'b1;
      seq_r.reset_ind_n_r <= 1'b0;
      seq_r.offchip_boot_r <= 1'b0;
      seq_r.debug_reset_r <= 1'b1;
      seq_r.irq_a_r <= 1'b0;
      seq_r.irq_b_r <= 1'b0;
    end
    else
      seq_r <= seq_nxt;
  end

  assign core_reset_out = seq_r.core_reset_r;
  assign reset_indicator_n_out = seq_r.reset_ind_n_r;
  assign offchip_boot_out = seq_r.offchip_boot_r;
  // Core-only reset: debug_reset_r is raised by the pin reset in RBI_IN_RESET and drops in RBI_COUNTING
  assign core_only_reset_out = seq_r.debug_reset_r;
  assign irq_a_out = seq_r.irq_a_r;
  assign irq_b_out = seq_r.irq_b_r;

endmodule
`default_nettype wire

// ===== testbench/rbi_reset_boot_irq_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module rbi_reset_boot_irq_assertions #(
  parameter int unsigned RELEASE_CYCLES = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ext_reset_n_in,
  input wire logic offchip_boot_select_in,
  input wire logic ext_request_a_n_in,
  input wire logic ext_request_b_n_in,
  input wire rbi_pkg::rbi_irq_cfg_type cfg_a_in,
  input wire rbi_pkg::rbi_irq_cfg_type cfg_b_in,
  input wire logic ack_b_in,
  input wire logic core_reset_out,
  input wire logic reset_indicator_n_out,
  input wire logic offchip_boot_out,
  input wire logic core_only_reset_out,
  input wire logic irq_a_out,
  input wire logic irq_b_out
);
  // Cycles the reset pin has been high, saturating
  logic [7:0] hi_r;
  always_ff @(posedge clk_in)
  begin
    hi_r <= (srst_in || !ext_reset_n_in) ? 8'h00 : hi_r + {7'h00, hi_r != 8'hff};
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_ind_mirror: assert property (
    reset_indicator_n_out == !core_reset_out)
    else $error("indicator differs from internal reset");
  // Core reset rises after the pin is seen low; the core-only flag a cycle later
  a_pin_holds: assert property (
    !ext_reset_n_in [*3] |=> core_reset_out ##1 core_only_reset_out)
    else $error("core not held in reset while pin low");
  a_release_count: assert property (
    $fell(core_reset_out) |-> hi_r inside {[RELEASE_CYCLES+3:RELEASE_CYCLES+5]})
    else $error("internal reset released at wrong cycle");
  // Strap is taken two edges before the core-only flag is seen to fall
  a_boot_capture: assert property (
    $fell(core_only_reset_out) |-> offchip_boot_out == $past(offchip_boot_select_in, 2))
    else $error("boot level not captured at release");
  a_level_a: assert property (
    (!core_reset_out && cfg_a_in == 2'h1 && !ext_request_a_n_in) [*4] |=> irq_a_out)
    else $error("level request a not raised");
  a_level_b: assert property (
    (cfg_b_in == 2'h1 && ext_request_b_n_in) [*4] |=> !irq_b_out)
    else $error("level request b raised with pin high");
  a_edge_a: assert property (
    $fell(ext_request_a_n_in) && cfg_a_in == 2'h3 && !core_reset_out |-> ##[2:5] irq_a_out)
    else $error("falling edge on a not latched");
  // The output trails the latch by one cycle, so an ack one edge back still clears it
  a_edge_b: assert property (
    cfg_b_in == 2'h3 && irq_b_out && !core_reset_out && !ack_b_in && !$past(ack_b_in)
    |=> irq_b_out)
    else $error("edge request b lost without ack");
endmodule
bind rbi_reset_boot_irq rbi_reset_boot_irq_assertions #(.RELEASE_CYCLES(RELEASE_CYCLES)) chk (.*);
`default_nettype wire

// ===== testbench/rbi_board_model.sv
`timescale 1ns/1ns
`default_nettype none
module rbi_board_model (
  input wire logic clk_in,
  output var logic reset_n_out,
  output var logic test_reset_n_out,
  output var logic boot_out,
  output var logic req_a_n_out,
  output var logic req_b_n_out
);
  initial
  begin
    {reset_n_out, test_reset_n_out, boot_out, req_a_n_out, req_b_n_out} = 5'h03;
  end
  // Pins change just after an edge
  task automatic drive(input logic rst_n, input logic keep_dbg, input logic strap,
    input logic a_n, input logic b_n);
    @(posedge clk_in);
    reset_n_out <= rst_n;
    test_reset_n_out <= rst_n | keep_dbg;
    boot_out <= strap;
    req_a_n_out <= a_n;
    req_b_n_out <= b_n;
  endtask
endmodule
`default_nettype wire

// ===== testbench/rbi_reset_boot_irq_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) \
  begin tests_run++; if ((g) !== (e)) \
  begin err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module rbi_reset_boot_irq_bench;
  localparam int unsigned RC = 4;
  logic clk_in = 1'h0;
  logic srst_in = 1'h1;
  logic rst_n, boot, req_a_n, req_b_n, core_rst, ind_n, boot_q, core_only, irq_a, irq_b;
  rbi_pkg::rbi_irq_cfg_type cfg = 2'h0;
  logic ack = 1'h0;
  int err_count = 0;
  int tests_run = 0;
  always #2 clk_in = ~clk_in;
  rbi_board_model board (.clk_in(clk_in), .reset_n_out(rst_n), .test_reset_n_out(),
    .boot_out(boot), .req_a_n_out(req_a_n), .req_b_n_out(req_b_n));
  rbi_reset_boot_irq #(.RELEASE_CYCLES(RC)) uut (.clk_in(clk_in), .srst_in(srst_in),
    .ext_reset_n_in(rst_n), .offchip_boot_select_in(boot), .ext_request_a_n_in(req_a_n),
    .ext_request_b_n_in(req_b_n), .cfg_a_in(cfg), .cfg_b_in(cfg), .ack_a_in(ack),
    .ack_b_in(ack), .core_reset_out(core_rst), .reset_indicator_n_out(ind_n),
    .offchip_boot_out(boot_q), .core_only_reset_out(core_only), .irq_a_out(irq_a),
    .irq_b_out(irq_b));
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_boot(input logic strap);
    int n;
    n = 0;
    board.drive(1'h0, strap, strap, 1'h1, 1'h1);
    repeat (5) @(posedge clk_in);
    #1 `CHK("held", 3'h5, {core_rst, ind_n, core_only})
    board.drive(1'h1, 1'h0, strap, 1'h1, 1'h1);
    while (core_rst === 1'h1 && n < 40)
      @(posedge clk_in) #1 n++;
    `CHK("release", 1'h1, (n >= RC + 3 && n <= RC + 5))
    `CHK("after", {1'h1, strap, 1'h0}, {ind_n, boot_q, core_only})
    board.drive(1'h1, 1'h0, ~strap, 1'h1, 1'h1);
    repeat (3) @(posedge clk_in);
    #1 `CHK("strap late", strap, boot_q)
    if (n == 40) end_sim();
  endtask
  task automatic t_irq(input logic em);
    @(posedge clk_in) cfg <= '{edge_mode: em, enable: 1'h1};
    board.drive(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    if (em) board.drive(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    repeat (5) @(posedge clk_in);
    #1 `CHK("irq on", 2'h3, {irq_a, irq_b})
    board.drive(1'h1, 1'h0, 1'h0, 1'h1, 1'h1);
    ack <= em;
    @(posedge clk_in) ack <= 1'h0;
    repeat (5) @(posedge clk_in);
    #1 `CHK("irq off", 2'h0, {irq_a, irq_b})
  endtask
  task automatic t_off;
    @(posedge clk_in) cfg <= 2'h0;
    board.drive(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    repeat (5) @(posedge clk_in);
    #1 `CHK("disabled", 2'h0, {irq_a, irq_b})
  endtask
  initial
  begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'h0;
    t_boot(1'h1);
    t_boot(1'h0);
    t_irq(1'h1);
    t_irq(1'h0);
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
